// >>> rtl/nvc_top.sv
/*
  Command decoder and power-state controller of a serial nvSRAM.
  Assumes scl/sda come from an external bus master, power_fail_pin
  from an analog comparator, sram_write from memory logic on mclk.
*/
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_top
  import nvc_pkg::*;
#(
  parameter int unsigned SAVE_CYC = `NVC_SAVE_TIME_US * `NVC_MCLK_MHZ,
  parameter int unsigned REST_CYC = `NVC_RESTORE_TIME_US * `NVC_MCLK_MHZ,
  parameter int unsigned SETTLE_CYC = `NVC_SETTLE_TIME_US * `NVC_MCLK_MHZ,
  parameter int unsigned DOZE_CYC = `NVC_DOZE_TIME_US * `NVC_MCLK_MHZ,
  parameter int unsigned WAKE_CYC = `NVC_WAKE_TIME_US * `NVC_MCLK_MHZ
)
(
  input wire logic mclk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic ce, // Clock enable, mclk side
  input wire logic scl, // Bus clock
  input wire logic sda_i, // Bus data in
  output logic sda_o, // Bus data out, always low
  output logic sda_oe, // Bus data drive enable
  input wire logic write_lock_pin, // Write lock, high blocks
  input wire logic power_fail_pin, // Supply below threshold
  input wire logic sram_write, // One-cycle SRAM write pulse
  output logic busy_store_pin_o, // Busy pin level, always low
  output logic busy_store_pin_oe, // Busy pin drive enable
  output nvc_stat_t stat // Controller status
);

  // ---------------- Link side, bus clock ----------------
  logic st_tgl_r; // Start toggle, sda fall
  logic st_seen_r; // Last start handled
  logic st_seen_nxt;
  logic [7:0] sh_r; // Shift register
  logic [7:0] sh_nxt;
  logic [3:0] bit_r; // Bits of the byte taken
  logic [3:0] bit_nxt;
  nvc_link_t ph_r; // Byte position in frame
  nvc_link_t ph_nxt;
  logic ack_r; // Acknowledge the current byte
  logic ack_nxt;
  logic [7:0] cmd_r; // Command byte for mclk side
  logic [7:0] cmd_nxt;
  logic cmd_tgl_r; // Command event toggle
  logic cmd_tgl_nxt;
  logic wake_tgl_r; // Address event toggle
  logic wake_tgl_nxt;
  logic rdy_r; // Controller idle, mclk side, read through rdy_ls_r
  logic [1:0] rdy_ls_r; // Ready synchroniser
  logic [1:0] wp_ls_r; // Write-lock synchroniser
  logic zero_r; // Constant low for open-drain pins
  logic sda_oe_r; // Ack drive, falling scl
  logic [7:0] byte_in; // Byte completed this edge
  logic new_frame;
  logic [3:0] nib;
  logic tgt_hit;

  // Start: sda falls while scl high; stable long before next scl rise
  always_ff @(negedge sda_i or negedge reset_n)
  begin
    if (!reset_n)
      st_tgl_r <= 1'b0;
    else if (scl)
      st_tgl_r <= ~st_tgl_r;
  end

  assign byte_in = {sh_r[6:0], sda_i};
  assign new_frame = st_tgl_r != st_seen_r;
  assign nib = byte_in[7:4];
  // Any of the three targets with our select bits
  assign tgt_hit = (byte_in[3:1] == `NVC_DEV_SEL) &&
    (nib == `NVC_TGT_CTRL || nib == `NVC_TGT_MEM || nib == `NVC_TGT_RTC);

  // Byte assembly and decode on each scl rise
  always_comb
  begin
    st_seen_nxt = st_seen_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    ph_nxt = ph_r;
    ack_nxt = ack_r;
    cmd_nxt = cmd_r;
    cmd_tgl_nxt = cmd_tgl_r;
    wake_tgl_nxt = wake_tgl_r;
    if (new_frame)
    begin
      // Start or repeated start: first address bit now
      st_seen_nxt = st_tgl_r;
      sh_nxt = {7'h00, sda_i};
      bit_nxt = 4'h1;
      ph_nxt = L_ADDR;
      ack_nxt = 1'b0;
    end
    else if (ph_r == L_IDLE)
    begin
      // Frame refused; wait for next start
      bit_nxt = 4'h0;
    end
    else if (bit_r == 4'h8)
    begin
      // Ack slot done; a NACK ends our part of the frame
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
      if (!ack_r)
        ph_nxt = L_IDLE;
    end
    else
    begin
      sh_nxt = byte_in;
      bit_nxt = bit_r + 4'h1;
      if (bit_r == 4'h7)
      begin
        unique case (ph_r)
          L_ADDR:
          begin
            if (tgt_hit)
              wake_tgl_nxt = ~wake_tgl_r;
            // Busy or asleep: NACK, master polls again
            ack_nxt = rdy_ls_r[1] && nib == `NVC_TGT_CTRL &&
              !byte_in[0] && byte_in[3:1] == `NVC_DEV_SEL;
            ph_nxt = L_OFF;
          end
          L_OFF:
          begin
            // Only the command location is served here
            ack_nxt = byte_in == `NVC_CMD_OFFSET;
            ph_nxt = L_DATA;
          end
          L_DATA:
          begin
            ack_nxt = !wp_ls_r[1];
            if (!wp_ls_r[1])
            begin
              cmd_nxt = byte_in;
              cmd_tgl_nxt = ~cmd_tgl_r;
            end
          end
          L_IDLE:
          begin
            ack_nxt = 1'b0;
          end
        endcase
      end
    end
  end

  // Link state registers
  always_ff @(posedge scl or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_seen_r <= 1'b0;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      ph_r <= L_IDLE;
      ack_r <= 1'b0;
      cmd_r <= 8'h00;
      cmd_tgl_r <= 1'b0;
      wake_tgl_r <= 1'b0;
      rdy_ls_r <= 2'h0;
      wp_ls_r <= 2'h3;
    end
    else
    begin
      st_seen_r <= st_seen_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      ph_r <= ph_nxt;
      ack_r <= ack_nxt;
      cmd_r <= cmd_nxt;
      cmd_tgl_r <= cmd_tgl_nxt;
      wake_tgl_r <= wake_tgl_nxt;
      rdy_ls_r <= {rdy_ls_r[0], rdy_r};
      wp_ls_r <= {wp_ls_r[0], write_lock_pin};
    end
  end

  // Ack drive changes on falling scl, held across the ninth rise
  always_ff @(negedge scl or negedge reset_n)
  begin
    if (!reset_n)
      sda_oe_r <= 1'b0;
    else
      sda_oe_r <= (bit_r == 4'h8) && ack_r;
  end

  // ---------------- Controller side, mclk ----------------
  nvc_state_t st_r; // Controller state
  nvc_state_t st_nxt;
  logic [19:0] tmr_r; // Interval timer
  logic [19:0] tmr_nxt;
  logic dirty_r; // SRAM written since last nv op
  logic dirty_clr;
  logic as_en_r; // Auto save enable, volatile
  logic as_en_nxt;
  logic as_nv_r; // Auto save enable, nv copy
  logic as_nv_nxt;
  logic sv_r; // Save in progress
  logic sv_nxt;
  logic [2:0] cmd_s_r; // Command toggle synchroniser
  logic [2:0] wake_s_r; // Address toggle synchroniser
  logic [1:0] pf_s_r; // Power-fail synchroniser
  logic busy_oe_r; // Busy pin drive, save running
  nvc_stat_t stat_r;
  nvc_stat_t stat_nxt;
  logic cmd_ev;
  logic wake_ev;
  logic pf_trip;
  logic sv_end;

  assign cmd_ev = cmd_s_r[2] ^ cmd_s_r[1];
  assign wake_ev = wake_s_r[2] ^ wake_s_r[1];
  // Power fail matters only with auto save on
  assign pf_trip = pf_s_r[1] && as_en_r && st_r != S_PUP && st_r != S_PF;

  // Next controller state
  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r + 20'h00001;
    dirty_clr = 1'b0;
    as_en_nxt = as_en_r;
    as_nv_nxt = as_nv_r;
    sv_nxt = sv_r;
    sv_end = 1'b0;
    if (pf_trip)
    begin
      // Conditional save from the hold-up capacitor
      st_nxt = S_PF;
      tmr_nxt = 20'h00000;
      sv_nxt = dirty_r;
    end
    else
    begin
      unique case (st_r)
        S_PUP:
        begin
          // Restore at power-up is unconditional
          if (tmr_r == 20'(REST_CYC - 1))
          begin
            dirty_clr = 1'b1;
            as_en_nxt = as_nv_r;
            st_nxt = S_IDLE;
          end
        end
        S_IDLE:
        begin
          tmr_nxt = 20'h00000;
          if (cmd_ev)
          begin
            unique case (cmd_r)
              `NVC_CMD_SAVE:
              begin
                st_nxt = S_SAVE;
                sv_nxt = 1'b1;
              end
              `NVC_CMD_RESTORE:
                st_nxt = S_REST;
              `NVC_CMD_AS_ON:
              begin
                as_en_nxt = 1'b1;
                st_nxt = S_SETTLE;
              end
              `NVC_CMD_AS_OFF:
              begin
                as_en_nxt = 1'b0;
                st_nxt = S_SETTLE;
              end
              `NVC_CMD_SLEEP:
                st_nxt = S_SLP;
              default:
                st_nxt = S_IDLE;
            endcase
          end
        end
        S_SAVE:
        begin
          if (tmr_r == 20'(SAVE_CYC - 1))
          begin
            sv_end = 1'b1;
            st_nxt = S_IDLE;
          end
        end
        S_REST:
        begin
          // Cells untouched: nv copy is not written here
          if (tmr_r == 20'(REST_CYC - 1))
          begin
            dirty_clr = 1'b1;
            st_nxt = S_IDLE;
          end
        end
        S_SETTLE:
        begin
          if (tmr_r == 20'(SETTLE_CYC - 1))
            st_nxt = S_IDLE;
        end
        S_SLP:
        begin
          // Timer runs from registration of the command
          if (tmr_r == 20'(SETTLE_CYC - 1))
            sv_nxt = dirty_r;
          if (sv_r && tmr_r == 20'(SETTLE_CYC + SAVE_CYC - 1))
            sv_end = 1'b1;
          if (tmr_r == 20'(DOZE_CYC - 1))
            st_nxt = S_DOZE;
        end
        S_DOZE:
        begin
          tmr_nxt = 20'h00000;
          if (wake_ev)
            st_nxt = S_WAKE;
        end
        S_WAKE:
        begin
          if (tmr_r == 20'(WAKE_CYC - 1))
            st_nxt = S_IDLE;
        end
        S_PF:
        begin
          if (sv_r && tmr_r == 20'(SAVE_CYC - 1))
            sv_end = 1'b1;
          // Supply back: behave as a fresh power-up
          if (!pf_s_r[1])
          begin
            st_nxt = S_PUP;
            tmr_nxt = 20'h00000;
          end
        end
        default:
        begin
          st_nxt = S_PUP;
          tmr_nxt = 20'h00000;
        end
      endcase
    end
    if (sv_end)
    begin
      // A save also fixes the auto-save setting in the cells
      sv_nxt = 1'b0;
      dirty_clr = 1'b1;
      as_nv_nxt = as_en_r;
    end
    stat_nxt.asleep = st_nxt == S_DOZE;
    stat_nxt.blocked = st_nxt != S_IDLE;
    stat_nxt.auto_en = as_en_nxt;
    stat_nxt.saving = sv_nxt;
    stat_nxt.restoring = st_nxt == S_REST || st_nxt == S_PUP;
  end

  // Controller registers; ce freezes all of them
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= S_PUP;
      tmr_r <= 20'h00000;
      dirty_r <= 1'b0;
      as_en_r <= `NVC_AUTO_EN_RST;
      as_nv_r <= `NVC_AUTO_EN_RST;
      sv_r <= 1'b0;
      rdy_r <= 1'b0;
      busy_oe_r <= 1'b0;
      stat_r <= '0;
      cmd_s_r <= 3'h0;
      wake_s_r <= 3'h0;
      pf_s_r <= 2'h0;
      zero_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      // A write in the clearing cycle keeps the flag set
      dirty_r <= sram_write | (dirty_r & ~dirty_clr);
      as_en_r <= as_en_nxt;
      as_nv_r <= as_nv_nxt;
      sv_r <= sv_nxt;
      rdy_r <= st_nxt == S_IDLE;
      busy_oe_r <= sv_nxt;
      stat_r <= stat_nxt;
      cmd_s_r <= {cmd_s_r[1:0], cmd_tgl_r};
      wake_s_r <= {wake_s_r[1:0], wake_tgl_r};
      pf_s_r <= {pf_s_r[0], power_fail_pin};
      zero_r <= 1'b0;
    end
  end

  assign sda_o = zero_r;
  assign sda_oe = sda_oe_r;
  assign busy_store_pin_o = zero_r;
  assign busy_store_pin_oe = busy_oe_r;
  assign stat = stat_r;

endmodule // nvc_top

// >>> rtl/nvc_defines.svh
/*
  Constants of the nonvolatile command and sleep controller.
  Assumes a 25 MHz mclk; times are in microseconds.
*/
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH
`define NVC_CMD_OFFSET 8'hAA
`define NVC_CMD_SAVE 8'h3C
`define NVC_CMD_RESTORE 8'h60
`define NVC_CMD_AS_ON 8'h59
`define NVC_CMD_AS_OFF 8'h19
`define NVC_CMD_SLEEP 8'hB9
`define NVC_TGT_CTRL 4'h3
`define NVC_TGT_MEM 4'hA
`define NVC_TGT_RTC 4'hD
`define NVC_DEV_SEL 3'h0
`define NVC_AUTO_EN_RST 1'b1
`define NVC_MCLK_MHZ 25
`define NVC_SAVE_TIME_US 8000
`define NVC_RESTORE_TIME_US 20000
`define NVC_SETTLE_TIME_US 100
`define NVC_DOZE_TIME_US 10000
`define NVC_WAKE_TIME_US 20000
`endif

// >>> rtl/nvc_pkg.sv
/*
  Types of the nonvolatile command and sleep controller.
  Assumes nvc_defines.svh is on the include path.
*/
package nvc_pkg;
  // Main controller states
  typedef enum logic [3:0] {
    S_PUP = 4'h0,
    S_IDLE = 4'h1,
    S_SAVE = 4'h2,
    S_REST = 4'h3,
    S_SETTLE = 4'h4,
    S_SLP = 4'h5,
    S_DOZE = 4'h6,
    S_WAKE = 4'h7,
    S_PF = 4'h8
  } nvc_state_t;
  // Byte position within a bus frame
  typedef enum logic [1:0] {
    L_ADDR = 2'h0,
    L_OFF = 2'h1,
    L_DATA = 2'h2,
    L_IDLE = 2'h3
  } nvc_link_t;
  // Status bundle shown to the rest of the chip
  typedef struct packed {
    logic asleep;
    logic blocked;
    logic auto_en;
    logic saving;
    logic restoring;
  } nvc_stat_t;
endpackage

// >>> testbench/nvc_top_assertions.sv
/*
  Checker of the command and sleep controller, bound to nvc_top.
  Assumes the bind hands on the small timing parameters.
*/
`timescale 1ns/1ps
module nvc_checker
  import nvc_pkg::*;
#(
  parameter int unsigned SAVE_CYC = 20,
  parameter int unsigned REST_CYC = 30
)
(
  input wire logic mclk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic ce, // Clock enable
  input wire logic scl, // Bus clock
  input wire logic sda_o, // Bus data out
  input wire logic sda_oe, // Bus data enable
  input wire logic power_fail_pin, // Supply low
  input wire logic busy_store_pin_o, // Busy level
  input wire logic busy_store_pin_oe, // Busy enable
  input wire nvc_stat_t stat // Status
);
  logic [19:0] busy_cnt_r; // Cycles of current save
  logic [19:0] busy_cnt_nxt; // Next save count
  logic [19:0] rest_cnt_r; // Cycles of current restore
  logic [19:0] rest_cnt_nxt; // Next restore count
  logic pup_r; // First cycle after reset
  // Count lengths, since a repetition cannot reach these spans
  always_comb
  begin
    busy_cnt_nxt = busy_store_pin_oe ? busy_cnt_r + 20'h00001 : 20'h00000;
    // Power-up restore runs before the status first shows it
    rest_cnt_nxt = (stat.restoring || pup_r) ? rest_cnt_r + 20'h00001 : 20'h00000;
  end
  // Counters freeze with ce, as the controller does
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_cnt_r <= 20'h00000;
      rest_cnt_r <= 20'h00000;
      pup_r <= 1'b1;
    end
    else if (ce)
    begin
      busy_cnt_r <= busy_cnt_nxt;
      rest_cnt_r <= rest_cnt_nxt;
      pup_r <= 1'b0;
    end
  end
  // Ends of the two long operations
  sequence s_save_end;
    busy_store_pin_oe ##1 !busy_store_pin_oe;
  endsequence
  sequence s_rest_end;
    stat.restoring ##1 !stat.restoring;
  endsequence
  a_save_len_exact: assert property (@(posedge mclk) disable iff (!reset_n)
    s_save_end |-> busy_cnt_r == 20'(SAVE_CYC)) else $error("save length wrong");
  a_rest_len_exact: assert property (@(posedge mclk) disable iff (!reset_n)
    s_rest_end |-> rest_cnt_r == 20'(REST_CYC)) else $error("restore length wrong");
  a_busy_while_save: assert property (@(posedge mclk) disable iff (!reset_n)
    busy_store_pin_oe |-> stat.saving && stat.blocked && !busy_store_pin_o)
    else $error("busy pin without save");
  a_sleep_silent: assert property (@(posedge mclk) disable iff (!reset_n)
    stat.asleep |-> !sda_oe && !busy_store_pin_oe) else $error("activity while asleep");
  a_ack_one_bit: assert property (@(negedge scl) disable iff (!reset_n)
    $rose(sda_oe) |=> !sda_oe && !sda_o) else $error("ack not one bit");
  a_auto_settle: assert property (@(posedge mclk) disable iff (!reset_n)
    $changed(stat.auto_en) && !$past(stat.restoring) |-> ##[0:1] stat.blocked)
    else $error("auto save change without settle");
  a_fail_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
    (power_fail_pin && stat.auto_en) [*4] |-> stat.blocked) else $error("fail not blocked");
  a_rest_no_save: assert property (@(posedge mclk) disable iff (!reset_n)
    stat.restoring |-> !stat.saving && !busy_store_pin_oe) else $error("save in restore");
endmodule // nvc_checker

bind nvc_top nvc_checker #(.SAVE_CYC(SAVE_CYC), .REST_CYC(REST_CYC)) u_nvc_checker (
  .mclk(mclk), .reset_n(reset_n), .ce(ce), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
  .power_fail_pin(power_fail_pin), .busy_store_pin_o(busy_store_pin_o),
  .busy_store_pin_oe(busy_store_pin_oe), .stat(stat));

// >>> testbench/nvc_bus_master.sv
/*
  Bus master model issuing command frames.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
module nvc_bus_master
(
  output logic scl, // Bus clock, only within frames
  output logic sda_low, // High while pulling data low
  input wire logic sda // Resolved data line
);
  // Idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit: data set in low phase, seen at the rise
  task bit_slot(input logic b, output logic seen);
    sda_low = !b;
    #15 scl = 1'b1;
    seen = sda;
    #15 scl = 1'b0;
  endtask
  // START, n bytes MSB first each with ack slot, STOP
  task frame(input logic [23:0] bytes, input int n, output logic [2:0] ak);
    logic seen;
    ak = 3'b000;
    sda_low = 1'b1;
    #15 scl = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      for (int j = 7; j >= 0; j--)
        bit_slot(bytes[8*i+j], seen);
      bit_slot(1'b1, seen);
      ak[i] = !seen;
    end
    sda_low = 1'b1;
    #15 scl = 1'b1;
    #15 sda_low = 1'b0;
    #30;
  endtask
endmodule // nvc_bus_master

// >>> testbench/nv_command_sleep_control_bench.sv
/*
  Self-checking bench of the command and sleep controller.
  Assumes the checker and bus master model are compiled first.
*/
`timescale 1ns/1ps
module nv_command_sleep_control_bench;
  import nvc_pkg::*;
  logic mclk = 1'b0; // System clock
  logic reset_n; // Async reset
  logic ce; // Clock enable, tied high
  logic write_lock_pin; // Write lock
  logic power_fail_pin; // Supply low
  logic sram_write; // SRAM write pulse
  logic scl; // Bus clock from master
  logic sda_low; // Master pull-down
  logic sda_o; // Device data level
  logic sda_oe; // Device data enable
  logic busy_store_pin_o; // Busy level
  logic busy_store_pin_oe; // Busy enable
  nvc_stat_t stat; // Status
  wire sda; // Resolved line, pulled up
  logic [2:0] ak; // Acks of last frame
  logic [7:0] bad_adr [3] = '{8'h31, 8'h32, 8'hA0}; // Targets not served here
  int miscompares; // Mismatches
  int samples_checked; // Comparisons
  assign sda = !(sda_low || (sda_oe && !sda_o));
  always #20 mclk = !mclk;
  nvc_top #(.SAVE_CYC(20), .REST_CYC(30), .SETTLE_CYC(10), .DOZE_CYC(50), .WAKE_CYC(30))
  u_nvc_top (.mclk(mclk), .reset_n(reset_n), .ce(ce), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .write_lock_pin(write_lock_pin),
    .power_fail_pin(power_fail_pin), .sram_write(sram_write),
    .busy_store_pin_o(busy_store_pin_o), .busy_store_pin_oe(busy_store_pin_oe), .stat(stat));
  nvc_bus_master u_nvc_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda));
  // Compare one status bit
  task check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Compare acks of a frame
  task check_ack(input string what, input logic [2:0] exp, input logic [2:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Frame of address, offset, code; leaves time for the event to cross
  task cmd(input logic [7:0] adr, off, code, input logic [2:0] exp);
    u_nvc_bus_master.frame({code, off, adr}, 3, ak);
    check_ack("frame acks", exp, ak);
    cyc(6);
  endtask
  // Bounded wait for the controller to unblock
  task wait_idle;
    int n;
    n = 0;
    while (stat.blocked !== 1'b0 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    check_bit("idle reached", 1'b1, n < 2000);
  endtask
  // Retry harmless frames until acked
  task poll;
    int n;
    n = 0;
    ak = 3'b000;
    while (ak !== 3'b111 && n < 30)
    begin
      u_nvc_bus_master.frame({8'h55, 8'hAA, 8'h30}, 3, ak);
      n++;
    end
    check_ack("poll acks", 3'b111, ak);
    cyc(6);
  endtask
  task pulse_write;
    sram_write = 1'b1;
    cyc(1);
    sram_write = 1'b0;
  endtask
  task wrap_up;
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence; hold-up capacitor assumed fitted, auto save may stay on
  initial
  begin
    reset_n = 1'b0;
    ce = 1'b1;
    write_lock_pin = 1'b0;
    power_fail_pin = 1'b0;
    sram_write = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cyc(2);
    reset_n = 1'b1;
    cyc(2);
    check_bit("power-up restore", 1'b1, stat.restoring);
    cmd(8'h30, 8'hAA, 8'h3C, 3'b000);
    wait_idle;
    check_bit("factory auto save", 1'b1, stat.auto_en);
    cmd(8'h30, 8'hAA, 8'h3C, 3'b111);
    check_bit("clean save runs", 1'b1, busy_store_pin_oe);
    check_bit("saving", 1'b1, stat.saving);
    wait_idle;
    cmd(8'h30, 8'hAA, 8'h60, 3'b111);
    check_bit("restoring", 1'b1, stat.restoring);
    wait_idle;
    cmd(8'h30, 8'hAA, 8'h19, 3'b111);
    check_bit("auto save off", 1'b0, stat.auto_en);
    check_bit("settle block", 1'b1, stat.blocked);
    wait_idle;
    cmd(8'h30, 8'hAA, 8'h3C, 3'b111);
    wait_idle;
    cmd(8'h30, 8'hAA, 8'h59, 3'b111);
    check_bit("auto save on", 1'b1, stat.auto_en);
    wait_idle;
    cmd(8'h30, 8'hAA, 8'h55, 3'b111);
    check_bit("unknown code", 1'b0, stat.blocked);
    cmd(8'h30, 8'h00, 8'h3C, 3'b001);
    check_bit("wrong offset", 1'b0, stat.blocked);
    foreach (bad_adr[i])
    begin
      cmd(bad_adr[i], 8'hAA, 8'h3C, 3'b000);
      check_bit("foreign target", 1'b0, stat.blocked);
    end
    write_lock_pin = 1'b1;
    cmd(8'h30, 8'hAA, 8'h3C, 3'b011);
    check_bit("locked command", 1'b0, stat.blocked);
    write_lock_pin = 1'b0;
    power_fail_pin = 1'b1;
    cyc(8);
    check_bit("fail blocks", 1'b1, stat.blocked);
    check_bit("clean fail save", 1'b0, busy_store_pin_oe);
    power_fail_pin = 1'b0;
    cyc(8);
    check_bit("restore after fail", 1'b1, stat.restoring);
    wait_idle;
    check_bit("volatile auto save", 1'b0, stat.auto_en);
    cmd(8'h30, 8'hAA, 8'h59, 3'b111);
    wait_idle;
    pulse_write;
    power_fail_pin = 1'b1;
    cyc(8);
    check_bit("dirty fail save", 1'b1, busy_store_pin_oe);
    cyc(30);
    power_fail_pin = 1'b0;
    wait_idle;
    check_bit("saved auto save", 1'b1, stat.auto_en);
    cmd(8'h30, 8'hAA, 8'hB9, 3'b111);
    cyc(10);
    check_bit("clean sleep save", 1'b0, busy_store_pin_oe);
    cyc(50);
    check_bit("asleep", 1'b1, stat.asleep);
    cmd(8'h30, 8'hAA, 8'h3C, 3'b000);
    poll;
    check_bit("wake frame ignored", 1'b0, busy_store_pin_oe);
    pulse_write;
    cmd(8'h30, 8'hAA, 8'hB9, 3'b111);
    cyc(10);
    check_bit("dirty sleep save", 1'b1, busy_store_pin_oe);
    cyc(60);
    check_bit("asleep", 1'b1, stat.asleep);
    u_nvc_bus_master.frame({16'h0000, 8'hD0}, 1, ak);
    poll;
    wrap_up;
  end
  // Watchdog: the run needs well under 100 us
  initial
  begin
    #400000;
    miscompares++;
    wrap_up;
  end
endmodule // nv_command_sleep_control_bench
